// ### src/rea_top.v
// Reactive energy accumulator with classic Wishbone register slave
`timescale 1ns/1ns
`include "rea_defines.vh"
// Behaviour
// - Reactive power sign positive for 0..+90 deg, negative for -90..0
// - Sign-direction bit clear: flag on positive-to-negative transition
// - Sign-direction bit set: flag on negative-to-positive transition
// - Sign-change interrupt pending while enabled until flag cleared
// - Below no-load threshold: no accumulation, no-load flag set
// - No-load interrupt pending while enabled until flag cleared
// - Level 00 off; 01,10,11 give 0.015, 0.0075, 0.0037 percent
// - Signed 49-bit hidden accumulator; upper 24 bits readable
// - One sample added every five master clock periods
// - Both mode bits clear: signed accumulation
// - Both mode bits set: absolute mode wins
// - Sign-steered mode: add when active positive, subtract when negative
// - Absolute mode: add magnitude, skip below active no-load
// - Divide by 8-bit divider; zero means divide by one
// - Read-clear register returns value, then clears upper 24 bits
// - Energy register wraps both directions and keeps counting
// - Half-full and overflow interrupts when enabled
// - Active-low pulse output proportional to power, mode honoured
// - Waveform samples at 25.6, 12.8, 6.4 or 3.2 kSPS
// - Line-cycle accumulation over programmed half cycles, zero-synced
// - Cycle end: flag, restart, overwrite line energy register
// - Count write clears line energy; start at next zero crossing
// - Half-cycle count is unsigned 16 bits
module rea_top #(
  parameter PULSE_SHIFT = 20,
  parameter PULSE_LOW_CLKS = 16'd1000
) (
  input wire clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire signed [23:0] reactive_power,
  input wire active_negative,
  input wire active_no_load,
  input wire voltage_zero_cross,
  output reg signed [23:0] waveform_sample_ff,
  output reg waveform_valid_ff,
  output wire calibration_pulse_out_n,
  output wire irq
);

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  reg ack_ff;
  // Registered ack: one cycle per taken request
  wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire [7:0] idx = wb_adr_i[9:2];
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire rd = req & ~wb_we_i;
  assign wb_ack_o = ack_ff;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= req;
  end

  reg [7:0] wavsrc_ff;
  reg [7:0] nlcfg_ff;
  reg [7:0] acccfg_ff;
  reg [7:0] irqen1_ff;
  reg [7:0] irqen3_ff;
  reg [7:0] reactive_energy_divider_ff;
  reg [15:0] half_cycle_count_ff;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wavsrc_ff <= `REA_RST8;
      nlcfg_ff <= `REA_RST8;
      acccfg_ff <= `REA_RST8;
      irqen1_ff <= `REA_RST8;
      irqen3_ff <= `REA_RST8;
      reactive_energy_divider_ff <= `REA_RST8;
      half_cycle_count_ff <= `REA_RST_HALF_CYCLE_COUNT;
    end
    else if (wr)
    begin
      case (idx)
        `REA_IDX_WAVSRC: wavsrc_ff <= wb_dat_i[7:0];
        `REA_IDX_NLCFG: nlcfg_ff <= wb_dat_i[7:0];
        `REA_IDX_ACCCFG: acccfg_ff <= wb_dat_i[7:0];
        `REA_IDX_IRQEN1: irqen1_ff <= wb_dat_i[7:0];
        `REA_IDX_IRQEN3: irqen3_ff <= wb_dat_i[7:0];
        `REA_IDX_REACTIVE_ENERGY_DIVIDER: reactive_energy_divider_ff <= wb_dat_i[7:0];
        `REA_IDX_HALF_CYCLE_COUNT:
        begin
          half_cycle_count_ff[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1])
            half_cycle_count_ff[15:8] <= wb_dat_i[15:8];
        end
        default: ;
      endcase
    end
  end

  wire sign_dir = acccfg_ff[`REA_ACC_SIGNDIR];
  wire abs_mode = acccfg_ff[`REA_ACC_ABSVAR];
  wire sav_mode = acccfg_ff[`REA_ACC_SAVAR] & ~abs_mode;
  wire [1:0] nl_lvl = nlcfg_ff[`REA_NL_LVL_HI:`REA_NL_LVL_LO];
  wire half_cycle_count_wr = wr & (idx == `REA_IDX_HALF_CYCLE_COUNT);
  wire rclr_rd = rd & (idx == `REA_IDX_REACTIVE_ENERGY_READ_CLEAR);

  // ----------------------------------------------------------------
  // Sample timing, sign, no-load
  // ----------------------------------------------------------------
  reg [2:0] tick_cnt_ff;
  wire tick = (tick_cnt_ff == `REA_SAMPLE_CLKS - 3'h1);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_ff <= 3'h0;
    else
      tick_cnt_ff <= tick ? 3'h0 : tick_cnt_ff + 3'h1;
  end

  // Sign taken straight from the signed power value
  wire neg_now = reactive_power[23];
  wire [23:0] mag = neg_now ? (~reactive_power + 24'h000001) :
    reactive_power;
  reg [23:0] nl_th;
  always @*
  begin
    case (nl_lvl)
      2'b01: nl_th = `REA_NL_TH1;
      2'b10: nl_th = `REA_NL_TH2;
      2'b11: nl_th = `REA_NL_TH3;
      default: nl_th = 24'h000000;
    endcase
  end
  wire no_load = (nl_lvl != 2'b00) & (mag < nl_th);

  // Sign history only moves on loaded samples
  reg neg_prev_ff;
  reg sign_seen_ff;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      neg_prev_ff <= 1'b0;
      sign_seen_ff <= 1'b0;
    end
    else if (tick & ~no_load)
    begin
      neg_prev_ff <= neg_now;
      sign_seen_ff <= 1'b1;
    end
  end
  wire sign_evt = tick & ~no_load & sign_seen_ff &
    (sign_dir ? (neg_prev_ff & ~neg_now)
              : (~neg_prev_ff & neg_now));

  // ----------------------------------------------------------------
  // Signed increment, divide, accumulate
  // ----------------------------------------------------------------
  reg signed [24:0] inc;
  always @*
  begin
    if (abs_mode)
      inc = active_no_load ? 25'sd0 : {1'b0, mag};
    else if (sav_mode)
      inc = active_negative ? -{reactive_power[23], reactive_power}
                            : {reactive_power[23], reactive_power};
    else
      inc = {reactive_power[23], reactive_power};
  end
  wire [7:0] div = (reactive_energy_divider_ff == 8'h00) ? 8'h01 : reactive_energy_divider_ff;
  wire signed [24:0] inc_div = inc / $signed({1'b0, div});
  wire add_en = tick & ~no_load;
  wire signed [48:0] inc_ext = {{24{inc_div[24]}}, inc_div};

  reg signed [48:0] acc_ff;
  wire signed [48:0] acc_sum = acc_ff + inc_ext;
  wire [23:0] acc_hi = acc_ff[48:25];
  wire [23:0] sum_hi = acc_sum[48:25];
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_ff <= 49'sd0;
    else if (rclr_rd)
      acc_ff <= {24'h000000, acc_ff[24:0]};
    else if (add_en)
      acc_ff <= acc_sum;
  end
  // Wrap: top bit flips while the increment pushes
  // in the direction of the old sign
  wire ovf_real = add_en & (acc_hi[23] ^ sum_hi[23]) &
    (inc_div[24] ? acc_hi[23] : ~acc_hi[23]);
  // Half full: magnitude crosses bit 22 in either sign
  wire half_evt = add_en & ((~acc_hi[23] & ~acc_hi[22] & sum_hi[22] &
    ~sum_hi[23]) | (acc_hi[23] & acc_hi[22] & ~sum_hi[22] & sum_hi[23]));

  // ----------------------------------------------------------------
  // Pulse output
  // ----------------------------------------------------------------
  // One carry out of PULSE_SHIFT bits gives one pulse
  reg [PULSE_SHIFT:0] pacc_ff;
  reg [15:0] plow_ff;
  // Magnitude of the mode-steered increment
  wire [24:0] pmag = inc[24] ? -inc : inc;
  wire [PULSE_SHIFT+24:0] pnext = {24'h000000, pacc_ff} +
    {{PULSE_SHIFT{1'b0}}, pmag};
  wire pcarry = |pnext[PULSE_SHIFT+24:PULSE_SHIFT];
  // A carry while the pulse is still low is dropped, not stretched
  wire pfire = add_en & pcarry & (plow_ff == 16'h0000);
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pacc_ff <= {(PULSE_SHIFT+1){1'b0}};
      plow_ff <= 16'h0000;
    end
    else
    begin
      if (add_en)
        pacc_ff <= {1'b0, pnext[PULSE_SHIFT-1:0]};
      if (pfire)
        plow_ff <= PULSE_LOW_CLKS;
      else if (plow_ff != 16'h0000)
        plow_ff <= plow_ff - 16'h0001;
    end
  end
  assign calibration_pulse_out_n = (plow_ff == 16'h0000);

  // ----------------------------------------------------------------
  // Waveform sampling
  // ----------------------------------------------------------------
  localparam [15:0] WAV_CLKS = `REA_WAV_BASE_NS / `REA_CLK_NS;
  reg [18:0] wav_cnt_ff;
  wire [18:0] wav_lim = {3'b000, WAV_CLKS} << wavsrc_ff[6:5];
  wire wav_sel = (wavsrc_ff[4:2] == 3'h0) &
    irqen3_ff[`REA_EN3_WAVEFORM_SAMPLE_ENABLE];
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wav_cnt_ff <= 19'h00000;
      waveform_sample_ff <= 24'sd0;
      waveform_valid_ff <= 1'b0;
    end
    else
    begin
      waveform_valid_ff <= 1'b0;
      if (!wav_sel)
        wav_cnt_ff <= 19'h00000;
      else if (wav_cnt_ff >= wav_lim - 19'h00001)
      begin
        wav_cnt_ff <= 19'h00000;
        waveform_sample_ff <= reactive_power;
        waveform_valid_ff <= 1'b1;
      end
      else
        wav_cnt_ff <= wav_cnt_ff + 19'h00001;
    end
  end

  // ----------------------------------------------------------------
  // Line-cycle accumulation
  // ----------------------------------------------------------------
  reg lc_run_ff;
  reg [15:0] hc_cnt_ff;
  reg signed [48:0] lacc_ff;
  reg [23:0] line_reactive_energy_ff;
  // Line sum including the sample of the closing cycle
  wire signed [48:0] lsum = lacc_ff + inc_ext;
  // Next period starts in the same cycle as cycle end
  wire hc_end = lc_run_ff & voltage_zero_cross &
    (hc_cnt_ff + 16'h0001 >= half_cycle_count_ff);
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lc_run_ff <= 1'b0;
      hc_cnt_ff <= 16'h0000;
      lacc_ff <= 49'sd0;
      line_reactive_energy_ff <= 24'h000000;
    end
    else if (half_cycle_count_wr)
    begin
      lc_run_ff <= 1'b0;
      hc_cnt_ff <= 16'h0000;
      lacc_ff <= 49'sd0;
      line_reactive_energy_ff <= 24'h000000;
    end
    else if (!lc_run_ff)
    begin
      if (voltage_zero_cross)
        lc_run_ff <= 1'b1;
    end
    else if (hc_end)
    begin
      hc_cnt_ff <= 16'h0000;
      line_reactive_energy_ff <= add_en ? lsum[48:25] : lacc_ff[48:25];
      lacc_ff <= 49'sd0;
    end
    else
    begin
      if (voltage_zero_cross)
        hc_cnt_ff <= hc_cnt_ff + 16'h0001;
      if (add_en)
        lacc_ff <= lacc_ff + inc_ext;
    end
  end

  // ----------------------------------------------------------------
  // Status flags and interrupt; set wins over clear
  // ----------------------------------------------------------------
  reg [7:0] st1_ff;
  reg [7:0] st3_ff;
  wire [7:0] set1 = {4'h0, ovf_real, half_evt, no_load & tick, sign_evt};
  wire [7:0] set3 = {7'h00, hc_end};
  wire [7:0] clr1 = (wr & idx == `REA_IDX_IRQST1) ? wb_dat_i[7:0] : 8'h00;
  wire [7:0] clr3 = (wr & idx == `REA_IDX_IRQST3) ? wb_dat_i[7:0] : 8'h00;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st1_ff <= `REA_RST8;
      st3_ff <= `REA_RST8;
    end
    else
    begin
      st1_ff <= (st1_ff & ~clr1) | set1;
      st3_ff <= (st3_ff & ~clr3) | set3;
    end
  end
  // Waveform enable bit is not an interrupt enable
  assign irq = |(st1_ff & irqen1_ff) | |(st3_ff & irqen3_ff &
    8'hFD);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h00000000;
    else if (rd)
    begin
      case (idx)
        `REA_IDX_WAVSRC: wb_dat_o <= {24'h000000, wavsrc_ff};
        `REA_IDX_NLCFG: wb_dat_o <= {24'h000000, nlcfg_ff};
        `REA_IDX_ACCCFG: wb_dat_o <= {24'h000000, acccfg_ff};
        `REA_IDX_IRQEN1: wb_dat_o <= {24'h000000, irqen1_ff};
        `REA_IDX_IRQEN3: wb_dat_o <= {24'h000000, irqen3_ff};
        `REA_IDX_IRQST1: wb_dat_o <= {24'h000000, st1_ff};
        `REA_IDX_IRQST3: wb_dat_o <= {24'h000000, st3_ff};
        `REA_IDX_REACTIVE_ENERGY_TOTAL: wb_dat_o <= {8'h00, acc_hi};
        `REA_IDX_REACTIVE_ENERGY_READ_CLEAR: wb_dat_o <= {8'h00, acc_hi};
        `REA_IDX_REACTIVE_ENERGY_DIVIDER: wb_dat_o <= {24'h000000, reactive_energy_divider_ff};
        `REA_IDX_LINE_REACTIVE_ENERGY: wb_dat_o <= {8'h00, line_reactive_energy_ff};
        `REA_IDX_HALF_CYCLE_COUNT: wb_dat_o <= {16'h0000, half_cycle_count_ff};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule // rea_top

// ### src/rea_defines.vh
// Register offsets, field positions, reset values and timing for the block
`ifndef REA_DEFINES_VH
`define REA_DEFINES_VH
// Register word indices (byte address = 4 * index)
`define REA_IDX_WAVSRC 8'h0D
`define REA_IDX_NLCFG 8'h0E
`define REA_IDX_ACCCFG 8'h0F
`define REA_IDX_IRQEN1 8'hD9
`define REA_IDX_IRQEN3 8'hDB
`define REA_IDX_IRQST1 8'hDC
`define REA_IDX_IRQST3 8'hDE
`define REA_IDX_REACTIVE_ENERGY_TOTAL 8'h40
`define REA_IDX_REACTIVE_ENERGY_DIVIDER 8'h41
`define REA_IDX_REACTIVE_ENERGY_READ_CLEAR 8'h42
`define REA_IDX_LINE_REACTIVE_ENERGY 8'h43
`define REA_IDX_HALF_CYCLE_COUNT 8'h44
// Field positions
`define REA_ACC_SIGNDIR 0
`define REA_ACC_SAVAR 1
`define REA_ACC_ABSVAR 2
`define REA_NL_LVL_LO 0
`define REA_NL_LVL_HI 1
`define REA_ST1_SIGN 0
`define REA_ST1_NOLOAD 1
`define REA_ST1_HALF 2
`define REA_ST1_OVF 3
`define REA_ST3_CYC 0
`define REA_EN3_WAVEFORM_SAMPLE_ENABLE 1
// Reset values
`define REA_RST8 8'h00
`define REA_RST_HALF_CYCLE_COUNT 16'hFFFF
// No-load thresholds in multiplier LSBs (full scale 2^24)
`define REA_NL_TH1 24'h000A11
`define REA_NL_TH2 24'h000509
`define REA_NL_TH3 24'h00026D
// Sample period: 5 master clocks
`define REA_SAMPLE_CLKS 3'h5
// Waveform rate: 25.6 kSPS base from 20 MHz
`define REA_WAV_BASE_NS 39062
`define REA_CLK_NS 50
`endif

// ### verif/rea_line_model.sv
// Line model: periodic voltage zero-crossing pulses
`timescale 1ns/1ns
module rea_line_model #(
  parameter PER = 40
) (
  input wire clk,
  input wire rst_n,
  output wire zc
);
  localparam [7:0] LAST = PER - 1;
  reg [7:0] cnt_ff;
  wire [7:0] nxt_cnt = (cnt_ff == LAST) ? 8'h00 : cnt_ff + 8'h01;
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= nxt_cnt;
  // One-cycle pulse per half line period
  assign zc = rst_n && (cnt_ff == LAST);
endmodule // rea_line_model

// ### verif/rea_top_monitor.sv
// Port checker for the reactive energy accumulator
`timescale 1ns/1ns
module rea_top_monitor #(
  parameter PULSE_LOW_CLKS = 16'd1000
) (
  input wire clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire waveform_valid_ff,
  input wire calibration_pulse_out_n,
  input wire irq
);
  reg [15:0] low_ff;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd = req && !wb_we_i;
  wire [7:0] ix = wb_adr_i[9:2];
  // Length of the current low phase of the pulse output
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      low_ff <= 16'h0000;
    else
      low_ff <= calibration_pulse_out_n ? 16'h0000 : low_ff + 16'h0001;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ack_taken; req |=> wb_ack_o; endproperty
  a_ack_taken: assert property (p_ack_taken) else $error("no ack");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  property p_unmapped; rd && ix == 8'hAA |=> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_count_hi; rd && ix == 8'h44 |=> wb_dat_o[31:16] == 16'h0;
  endproperty
  a_count_hi: assert property (p_count_hi) else $error("count width");
  property p_energy_hi; rd && ix >= 8'h40 && ix <= 8'h43
    |=> wb_dat_o[31:24] == 8'h00; endproperty
  a_energy_hi: assert property (p_energy_hi) else $error("energy width");
  property p_irq_hold; $fell(irq) |-> wb_ack_o && wb_we_i; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
  property p_low_max; low_ff <= PULSE_LOW_CLKS; endproperty
  a_low_max: assert property (p_low_max) else $error("pulse long");
  property p_low_len; $rose(calibration_pulse_out_n)
    |-> low_ff == PULSE_LOW_CLKS; endproperty
  a_low_len: assert property (p_low_len) else $error("pulse width");
  property p_wav_pulse; waveform_valid_ff |=> !waveform_valid_ff; endproperty
  a_wav_pulse: assert property (p_wav_pulse) else $error("valid long");
  c_irq: cover property (irq);
  c_wav: cover property (waveform_valid_ff);
  c_pulse: cover property ($fell(calibration_pulse_out_n));
endmodule // rea_top_monitor
bind rea_top rea_top_monitor #(.PULSE_LOW_CLKS(PULSE_LOW_CLKS)) u_mon (
  .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .waveform_valid_ff, .calibration_pulse_out_n, .irq);

// ### verif/rea_top_tb.sv
// Self-checking bench for the reactive energy accumulator
`timescale 1ns/1ns
`include "rea_defines.vh"
module rea_top_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [9:0] adr = 10'h000;
  reg [3:0] sel = 4'h0;
  reg [31:0] dat_i = 32'h0;
  reg signed [23:0] pwr = 24'sh0;
  reg an = 1'b0;
  reg anl = 1'b0;
  wire zc, cfo_n, irq, ack, wv;
  wire [31:0] dat_o;
  wire signed [23:0] wav;
  reg [31:0] rdv, r;
  reg [55:0] q;
  integer n_errors = 0;
  integer n_tests = 0;
  integer nf = 0;
  integer i, t;
  // Index, reset value, write value, read-back value
  localparam logic [55:0] REGS [8] = '{56'h0D_0000_0060_0060,
    56'h0E_0000_0003_0003, 56'h0F_0000_0007_0007, 56'hD9_0000_000F_000F,
    56'hDB_0000_0003_0003, 56'h41_0000_00FF_00FF, 56'h44_FFFF_0003_0003,
    56'hAA_0000_00FF_0000};
  // Mode, divider, flags (negative, active negative, active no-load), result
  localparam logic [31:0] MODES [8] = '{32'h0018_00F6, 32'h0000_000A,
    32'h0020_0005, 32'h4018_000A, 32'h401A_0000, 32'h601A_0000,
    32'h201C_000A, 32'h2014_00F6};
  rea_line_model #(.PER(40)) u_line (.clk(clk), .rst_n(rst_n), .zc(zc));
  rea_top #(.PULSE_SHIFT(8), .PULSE_LOW_CLKS(16'd4)) DUT (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .reactive_power(pwr), .active_negative(an),
    .active_no_load(anl), .voltage_zero_cross(zc), .waveform_sample_ff(wav),
    .waveform_valid_ff(wv), .calibration_pulse_out_n(cfo_n), .irq(irq));
  initial forever #25 clk = ~clk;
  always @(negedge cfo_n) nf = nf + 1;
  task check(input [31:0] seen, input [31:0] exp, input string nm);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  function near(input [23:0] a, input [23:0] b);
    reg [23:0] d;
    begin
      d = a - b;
      near = (d == 24'h0) || (d == 24'h1) || (d == 24'hFFFFFF);
    end
  endfunction
  task wb(input w, input [7:0] ix, input [31:0] d);
    begin
      t = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {ix, 2'b00};
      sel <= 4'hF;
      dat_i <= d;
      @(posedge clk);
      while (ack !== 1'b1 && t < 50)
      begin
        @(posedge clk);
        t = t + 1;
      end
      if (t >= 50)
        n_errors = n_errors + 1;
      rdv = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask
  task results;
    begin
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors = n_errors + 1;
    results;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 8; i = i + 1)
    begin
      q = REGS[i];
      wb(0, q[55:48], 32'h0);
      check(rdv, {16'h0, q[47:32]}, "reset value");
      wb(1, q[55:48], {16'h0, q[31:16]});
      wb(0, q[55:48], 32'h0);
      check(rdv, {16'h0, q[15:0]}, "read back");
    end
    wb(1, `REA_IDX_IRQEN3, 32'h0);
    for (i = 0; i < 8; i = i + 1)
    begin
      r = MODES[i];
      wb(1, `REA_IDX_ACCCFG, {28'h0, r[31:28]});
      wb(1, `REA_IDX_REACTIVE_ENERGY_DIVIDER, {24'h0, r[27:20]});
      pwr <= r[19] ? -24'sh400000 : 24'sh400000;
      an <= r[18];
      anl <= r[17];
      wb(0, `REA_IDX_REACTIVE_ENERGY_READ_CLEAR, 32'h0);
      repeat (400) @(posedge clk);
      wb(0, `REA_IDX_REACTIVE_ENERGY_READ_CLEAR, 32'h0);
      check(near(rdv[23:0], {{16{r[7]}}, r[7:0]}), 1, "energy");
      wb(0, `REA_IDX_REACTIVE_ENERGY_TOTAL, 32'h0);
      check(near(rdv[23:0], 24'h0), 1, "cleared");
    end
    an <= 1'b0;
    anl <= 1'b0;
    check(nf > 0, 1, "pulses");
    $display("modes done");
    for (i = 0; i < 2; i = i + 1)
    begin
      wb(1, `REA_IDX_ACCCFG, i);
      pwr <= i ? 24'sh400000 : -24'sh400000;
      repeat (20) @(posedge clk);
      wb(1, `REA_IDX_IRQST1, 32'hFF);
      wb(1, `REA_IDX_IRQEN1, 32'h01);
      pwr <= -pwr;
      repeat (20) @(posedge clk);
      check(irq, 0, "sign wrong way");
      pwr <= -pwr;
      repeat (20) @(posedge clk);
      wb(0, `REA_IDX_IRQST1, 32'h0);
      check({rdv[0], irq}, 2'b11, "sign flag");
      wb(1, `REA_IDX_IRQST1, 32'h01);
      check(irq, 0, "sign clear");
    end
    $display("sign done");
    wb(1, `REA_IDX_IRQEN1, 32'h02);
    pwr <= 24'sh000300;
    for (i = 0; i < 4; i = i + 1)
    begin
      wb(1, `REA_IDX_NLCFG, i);
      repeat (20) @(posedge clk);
      wb(1, `REA_IDX_IRQST1, 32'hFF);
      repeat (20) @(posedge clk);
      wb(0, `REA_IDX_IRQST1, 32'h0);
      check({rdv[1], irq}, {2{i == 1 || i == 2}}, "no-load");
    end
    wb(1, `REA_IDX_IRQEN1, 32'h0);
    wb(1, `REA_IDX_NLCFG, 32'h0);
    wb(1, `REA_IDX_ACCCFG, 32'h0);
    pwr <= 24'sh400000;
    wb(1, `REA_IDX_HALF_CYCLE_COUNT, 32'h2);
    wb(0, `REA_IDX_LINE_REACTIVE_ENERGY, 32'h0);
    check(rdv, 0, "line clear");
    wb(1, `REA_IDX_IRQEN3, 32'h01);
    for (i = 0; i < 2; i = i + 1)
    begin
      wb(1, `REA_IDX_IRQST3, 32'h01);
      while (irq !== 1'b1 && t < 300)
      begin
        @(posedge clk);
        t = t + 1;
      end
      check(irq, 1, "cycle done");
      wb(0, `REA_IDX_LINE_REACTIVE_ENERGY, 32'h0);
      check(near(rdv[23:0], 24'h2), 1, "line energy");
    end
    $display("line done");
    wb(1, `REA_IDX_IRQEN3, 32'h02);
    wb(1, `REA_IDX_WAVSRC, 32'h0);
    while (wv !== 1'b1 && t < 1000)
    begin
      @(posedge clk);
      t = t + 1;
    end
    check({wv, wav}, {1'b1, pwr}, "wave sample");
    $display("wave done");
    results;
  end
endmodule // rea_top_tb
